/* logic/egf_follower.sv */
/*
  egf_follower: electronic gearing follower. The follower velocity tracks
  an external quadrature master or an internal programmed velocity,
  rate-limited once per update interval.
  Assumes commands and data come from logic on clk_in as one-cycle pulses;
  the encoder pins are asynchronous and are synchronised here.
*/
`timescale 1ns/1ps
`default_nettype none

module egf_follower #(
  parameter int UPDATE_CYCLES = egf_pkg::UPDATE_CYCLES_DEF,
  parameter int ENC_LINES = egf_pkg::ENC_LINES_DEF,
  parameter int MOTOR_COUNTS = egf_pkg::MOTOR_COUNTS_DEF
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire egf_pkg::egf_cmd_type cmd_in,
  input wire logic ratio_write_in,
  input wire logic [egf_pkg::RATIO_W-1:0] ratio_data_in,
  input wire logic velocity_write_in,
  input wire logic [egf_pkg::VEL_W-1:0] velocity_data_in,
  input wire logic [egf_pkg::VEL_W-1:0] rate_limit_a_in,
  input wire logic position_write_in,
  input wire logic [egf_pkg::POS_W-1:0] indexed_position_in,
  input wire logic enc_a_in,
  input wire logic enc_b_in,
  output logic tracking_active_out,
  output logic external_selected_out,
  output logic [egf_pkg::RATIO_W-1:0] follower_master_ratio_out,
  output logic [egf_pkg::VEL_W-1:0] internal_master_velocity_out,
  output logic [egf_pkg::VEL_W-1:0] master_encoder_velocity_out,
  output logic [egf_pkg::VEL_W-1:0] follower_velocity_out,
  output logic [egf_pkg::POS_W-1:0] master_encoder_position_out,
  output logic [egf_pkg::POS_W-1:0] commanded_motor_position_out
);

  localparam int CNT_W = $clog2(UPDATE_CYCLES + 1);
  localparam logic [63:0] SCALE_NUM = 64'(MOTOR_COUNTS);
  localparam logic [63:0] SCALE_DEN = 64'(4 * ENC_LINES);

  // quadrature step from previous and current phase pair: -1, 0 or +1
  function automatic logic signed [1:0] quad_step(input logic [1:0] prev, input logic [1:0] cur);
    logic [3:0] idx;
    idx = {prev, cur};
    case (idx)
      4'h1, 4'h7, 4'hE, 4'h8: quad_step = 2'sb01;
      4'h2, 4'hB, 4'hD, 4'h4: quad_step = 2'sb11;
      default: quad_step = 2'sb00;
    endcase
  endfunction : quad_step

  function automatic logic [egf_pkg::RATIO_W-1:0] ratio_clamp(
    input logic [egf_pkg::RATIO_W-1:0] value
  );
    if (value > egf_pkg::RATIO_MAX) begin
      ratio_clamp = egf_pkg::RATIO_MAX;
    end else if (value < egf_pkg::RATIO_MIN) begin
      ratio_clamp = egf_pkg::RATIO_MIN;
    end else begin
      ratio_clamp = value;
    end
  endfunction : ratio_clamp

  // move cur toward tgt by at most rate
  function automatic logic signed [31:0] ramp(input logic signed [31:0] cur,
    input logic signed [31:0] tgt, input logic signed [31:0] rate);
    logic signed [32:0] diff;
    diff = 33'(tgt) - 33'(cur);
    if (diff > 33'(rate)) begin
      ramp = cur + rate;
    end else if (diff < -33'(rate)) begin
      ramp = cur - rate;
    end else begin
      ramp = tgt;
    end
  endfunction : ramp

  // encoder pin synchronisers: first stage read only by the second
  logic [1:0] enc_meta_reg;
  logic [1:0] enc_sync_reg;
  logic [1:0] enc_prev_reg;

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      enc_meta_reg <= 2'h0;
      enc_sync_reg <= 2'h0;
      enc_prev_reg <= 2'h0;
    end else begin
      enc_meta_reg <= {enc_a_in, enc_b_in};
      enc_sync_reg <= enc_meta_reg;
      enc_prev_reg <= enc_sync_reg;
    end
  end

  logic signed [1:0] step;
  assign step = quad_step(enc_prev_reg, enc_sync_reg);

  // control state: source, tracking, ratio, internal velocity
  egf_pkg::egf_state_type state_reg, state_next;
  logic ext_reg, ext_next;
  logic [egf_pkg::RATIO_W-1:0] ratio_reg, ratio_next;
  logic [egf_pkg::VEL_W-1:0] ivel_reg, ivel_next;

  always_comb begin
    ext_next = ext_reg;
    ratio_next = ratio_reg;
    ivel_next = ivel_reg;
    if (velocity_write_in) begin
      ivel_next = velocity_data_in;
    end
    if (ratio_write_in) begin
      ratio_next = ratio_clamp(ratio_data_in);
    end
    if (cmd_in.select_internal_master) begin
      ext_next = 1'b0;
    end
    if (cmd_in.select_external_master) begin
      ext_next = 1'b1;
    end
    if (cmd_in.program_start) begin
      ext_next = 1'b1;
      ratio_next = egf_pkg::RATIO_ONE;
    end
    state_next = state_reg;
    case (state_reg)
      egf_pkg::EGF_OFF: begin
        if (cmd_in.tracking_enable_cmd && !cmd_in.tracking_disable_cmd) begin
          state_next = egf_pkg::EGF_TRACK;
        end
      end
      egf_pkg::EGF_TRACK: begin
        if (cmd_in.tracking_disable_cmd) begin
          state_next = egf_pkg::EGF_OFF;
        end
      end
      default: state_next = egf_pkg::EGF_OFF;
    endcase
    // error and program start win over enable
    if (cmd_in.gearing_error || cmd_in.program_start) begin
      state_next = egf_pkg::EGF_OFF;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_reg <= egf_pkg::EGF_OFF;
      ext_reg <= 1'b1;
      ratio_reg <= egf_pkg::RATIO_ONE;
      ivel_reg <= egf_pkg::VEL_RESET;
    end else begin
      state_reg <= state_next;
      ext_reg <= ext_next;
      ratio_reg <= ratio_next;
      ivel_reg <= ivel_next;
    end
  end

  // measurement: interval timer, edge accumulator, master position
  logic [CNT_W-1:0] tick_cnt_reg, tick_cnt_next;
  logic tick;
  logic pos_clear;
  logic [egf_pkg::VEL_W-1:0] edge_acc_reg, edge_acc_next;
  logic [egf_pkg::VEL_W-1:0] mvel_reg, mvel_next;
  logic [egf_pkg::POS_W-1:0] mpos_reg, mpos_next;

  assign tick = (tick_cnt_reg == CNT_W'(UPDATE_CYCLES - 1));
  assign pos_clear = cmd_in.program_start || cmd_in.program_download || position_write_in;

  always_comb begin
    tick_cnt_next = tick ? '0 : tick_cnt_reg + CNT_W'(1);
    // edges per interval; an edge at the tick counts in both the ending and the next interval
    edge_acc_next = edge_acc_reg + 32'($signed(step));
    mvel_next = mvel_reg;
    if (tick) begin
      mvel_next = edge_acc_next;
      edge_acc_next = 32'($signed(step));
    end
    // two's complement wrap keeps counting in the same direction
    mpos_next = mpos_reg + 32'($signed(step));
    if (pos_clear) begin
      mpos_next = egf_pkg::POS_RESET;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      tick_cnt_reg <= '0;
      edge_acc_reg <= egf_pkg::VEL_RESET;
      mvel_reg <= egf_pkg::VEL_RESET;
      mpos_reg <= egf_pkg::POS_RESET;
    end else begin
      tick_cnt_reg <= tick_cnt_next;
      edge_acc_reg <= edge_acc_next;
      mvel_reg <= mvel_next;
      mpos_reg <= mpos_next;
    end
  end

  // follower: target, rate limiter, geared position
  logic signed [63:0] scaled_wide;
  logic signed [31:0] target;
  logic [egf_pkg::VEL_W-1:0] fvel_reg, fvel_next;
  logic [egf_pkg::POS_W-1:0] gpos_reg, gpos_next;
  logic [egf_pkg::POS_W-1:0] cpos_reg, cpos_next;

  // master counts times ratio, then encoder to motor counts
  assign scaled_wide = (($signed(64'($signed(mvel_reg))) * $signed({35'h0, ratio_reg}))
    >>> egf_pkg::RATIO_FRAC) * $signed(SCALE_NUM) / $signed(SCALE_DEN);

  always_comb begin
    target = 32'sh0000_0000;
    if (state_reg == egf_pkg::EGF_TRACK) begin
      // ratio only on external; internal value used unscaled
      target = ext_reg ? scaled_wide[31:0] : $signed(ivel_reg);
    end
    fvel_next = fvel_reg;
    gpos_next = gpos_reg;
    if (tick) begin
      // one step of at most the programmed rate per interval
      fvel_next = ramp($signed(fvel_reg), target, $signed(rate_limit_a_in));
      gpos_next = gpos_reg + fvel_next;
    end
    if (pos_clear) begin
      gpos_next = egf_pkg::POS_RESET;
    end
    cpos_next = indexed_position_in + gpos_reg;
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      fvel_reg <= egf_pkg::VEL_RESET;
      gpos_reg <= egf_pkg::POS_RESET;
      cpos_reg <= egf_pkg::POS_RESET;
    end else begin
      fvel_reg <= fvel_next;
      gpos_reg <= gpos_next;
      cpos_reg <= cpos_next;
    end
  end

  assign tracking_active_out = (state_reg == egf_pkg::EGF_TRACK);
  assign external_selected_out = ext_reg;
  // readback of ratio and internal velocity
  assign follower_master_ratio_out = ratio_reg;
  assign internal_master_velocity_out = ivel_reg;
  assign master_encoder_velocity_out = mvel_reg;
  assign follower_velocity_out = fvel_reg;
  assign master_encoder_position_out = mpos_reg;
  assign commanded_motor_position_out = cpos_reg;

  property p_ext_sel;
    @(posedge clk_in) disable iff (reset_in)
    cmd_in.select_external_master |=> external_selected_out;
  endproperty
  a_ext_sel: assert property (p_ext_sel) else $error("external select not taken");

  property p_int_sel;
    @(posedge clk_in) disable iff (reset_in)
    cmd_in.select_internal_master && !cmd_in.select_external_master && !cmd_in.program_start
      |=> !external_selected_out;
  endproperty
  a_int_sel: assert property (p_int_sel) else $error("internal select not taken");

  property p_enable;
    @(posedge clk_in) disable iff (reset_in)
    cmd_in.tracking_enable_cmd && !cmd_in.tracking_disable_cmd && !cmd_in.gearing_error
      && !cmd_in.program_start |=> tracking_active_out;
  endproperty
  a_enable: assert property (p_enable) else $error("enable did not start tracking");

  property p_force_off;
    @(posedge clk_in) disable iff (reset_in)
    cmd_in.gearing_error || cmd_in.program_start || cmd_in.tracking_disable_cmd
      |=> !tracking_active_out;
  endproperty
  a_force_off: assert property (p_force_off) else $error("tracking not forced off");

  property p_ratio_start;
    @(posedge clk_in) disable iff (reset_in)
    cmd_in.program_start |=> follower_master_ratio_out == egf_pkg::RATIO_ONE && external_selected_out;
  endproperty
  a_ratio_start: assert property (p_ratio_start) else $error("start defaults wrong");

  property p_ratio_range;
    @(posedge clk_in) disable iff (reset_in)
    ratio_write_in && !cmd_in.program_start |=>
      follower_master_ratio_out == ratio_clamp($past(ratio_data_in));
  endproperty
  a_ratio_range: assert property (p_ratio_range) else $error("ratio not clamped");

  property p_rate;
    @(posedge clk_in) disable iff (reset_in)
    tick |=> ($signed(follower_velocity_out) - $signed($past(follower_velocity_out))
      <= $signed($past(rate_limit_a_in))) && ($signed($past(follower_velocity_out))
      - $signed(follower_velocity_out) <= $signed($past(rate_limit_a_in)));
  endproperty
  a_rate: assert property (p_rate) else $error("follower step exceeds rate");

  property p_hold;
    @(posedge clk_in) disable iff (reset_in)
    !tick |=> $stable(follower_velocity_out);
  endproperty
  a_hold: assert property (p_hold) else $error("follower moved between ticks");

  property p_pos_clear;
    @(posedge clk_in) disable iff (reset_in)
    pos_clear |=> master_encoder_position_out == egf_pkg::POS_RESET
      ##1 commanded_motor_position_out == $past(indexed_position_in);
  endproperty
  a_pos_clear: assert property (p_pos_clear) else $error("position not cleared");

  property p_cmd_pos;
    @(posedge clk_in) disable iff (reset_in)
    !pos_clear ##1 !pos_clear |=> commanded_motor_position_out
      == $past(indexed_position_in) + $past(gpos_reg);
  endproperty
  a_cmd_pos: assert property (p_cmd_pos) else $error("commanded position sum wrong");

endmodule : egf_follower

`default_nettype wire

/* pkg/egf_pkg.sv */
/*
  egf_pkg: constants, states and command carrier for the electronic
  gearing follower. Assumes a 100 MHz system clock.
*/
`default_nettype none

package egf_pkg;

  // clock and velocity update interval
  localparam int CLK_PERIOD_NS = 10;
  localparam int UPDATE_TIME_NS = 1000000;
  localparam int UPDATE_CYCLES_DEF = (UPDATE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ratio: unsigned fixed point, 24 fraction bits, one step = 2^-24
  localparam int RATIO_W = 29;
  localparam int RATIO_FRAC = 24;
  localparam logic [RATIO_W-1:0] RATIO_ONE = 29'h0100_0000;
  localparam logic [RATIO_W-1:0] RATIO_MAX = 29'h1000_0000;
  localparam logic [RATIO_W-1:0] RATIO_MIN = 29'h0000_0001;

  // data widths and reset values
  localparam int VEL_W = 32;
  localparam int POS_W = 32;
  localparam logic [VEL_W-1:0] VEL_RESET = 32'h0000_0000;
  localparam logic [POS_W-1:0] POS_RESET = 32'h0000_0000;

  // scaling defaults: master encoder lines, follower counts per revolution
  localparam int ENC_LINES_DEF = 1000;
  localparam int MOTOR_COUNTS_DEF = 4000;

  typedef enum logic [1:0] {
    EGF_OFF = 2'b01,
    EGF_TRACK = 2'b10
  } egf_state_type;

  typedef struct packed {
    logic select_external_master;
    logic select_internal_master;
    logic tracking_enable_cmd;
    logic tracking_disable_cmd;
    logic program_start;
    logic program_download;
    logic gearing_error;
  } egf_cmd_type;

endpackage : egf_pkg

`default_nettype wire

/* tb/egf_encoder_model.sv */
/*
  egf_encoder_model: quadrature master encoder on the far side.
  Assumes clk_in is the bench clock; one step every four clocks while run.
*/
`timescale 1ns/1ps
`default_nettype none

module egf_encoder_model (
  input wire logic clk_in,
  input wire logic run_in,
  input wire logic dir_in,
  output logic enc_a_out,
  output logic enc_b_out
);
  logic [1:0] phase_reg = 2'h0;
  logic [1:0] div_reg = 2'h0;

  // fixed step rate keeps edges per interval constant
  always @(posedge clk_in) begin
    div_reg <= div_reg + 2'h1;
    if (run_in && div_reg == 2'h3) begin
      phase_reg <= dir_in ? phase_reg + 2'h1 : phase_reg - 2'h1;
    end
  end

  // gray order 00, 01, 11, 10; lines hold level when stopped
  assign enc_a_out = phase_reg[1];
  assign enc_b_out = phase_reg[1] ^ phase_reg[0];
endmodule : egf_encoder_model

`default_nettype wire

/* tb/egf_follower_tb_top.sv */
/*
  egf_follower_tb_top: self-checking bench for the gearing follower.
  Assumes a short update interval of 16 clocks and unit scaling.
*/
`timescale 1ns/1ps
`default_nettype none

module egf_follower_tb_top;
  logic clk_in, reset_in, ratio_write_in, velocity_write_in, position_write_in;
  logic run, dir, enc_a, enc_b, tracking, ext_sel;
  egf_pkg::egf_cmd_type cmd_in;
  logic [28:0] ratio_data_in, ratio_rb;
  logic [31:0] velocity_data_in, rate_in, index_pos, vel_rb, mvel, fvel, mpos, cpos;
  int num_errors = 0;
  int cmp_count = 0;
  int cycles = 0;

  // one interval of 16 clocks, four follower counts per four master edges
  egf_follower #(.UPDATE_CYCLES(16), .ENC_LINES(1), .MOTOR_COUNTS(4)) egf_follower_inst (
    .clk_in(clk_in), .reset_in(reset_in), .cmd_in(cmd_in),
    .ratio_write_in(ratio_write_in), .ratio_data_in(ratio_data_in),
    .velocity_write_in(velocity_write_in), .velocity_data_in(velocity_data_in),
    .rate_limit_a_in(rate_in), .position_write_in(position_write_in),
    .indexed_position_in(index_pos), .enc_a_in(enc_a), .enc_b_in(enc_b),
    .tracking_active_out(tracking), .external_selected_out(ext_sel),
    .follower_master_ratio_out(ratio_rb), .internal_master_velocity_out(vel_rb),
    .master_encoder_velocity_out(mvel), .follower_velocity_out(fvel),
    .master_encoder_position_out(mpos), .commanded_motor_position_out(cpos));

  egf_encoder_model egf_encoder_model_inst (
    .clk_in(clk_in), .run_in(run), .dir_in(dir), .enc_a_out(enc_a), .enc_b_out(enc_b));

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  task automatic chk(input string name, input logic [31:0] exp_v, input logic [31:0] got);
    cmp_count++;
    if (exp_v !== got) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", name, exp_v, got);
    end
  endtask : chk

  task automatic complete_run;
    if (num_errors == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run

  // hang guard: whole run needs well under 2000 clocks
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors++;
      complete_run();
    end
  end

  task automatic pulse_cmd(input logic [6:0] bits);
    @(negedge clk_in);
    cmd_in = egf_pkg::egf_cmd_type'(bits);
    @(negedge clk_in);
    cmd_in = egf_pkg::egf_cmd_type'(7'h00);
  endtask : pulse_cmd

  task automatic write_ratio(input logic [28:0] v);
    @(negedge clk_in);
    ratio_data_in = v;
    ratio_write_in = 1'b1;
    @(negedge clk_in);
    ratio_write_in = 1'b0;
  endtask : write_ratio

  // waits for the next tick change, bounded to 40 clocks, two and a half intervals
  task automatic step_vel(input logic [31:0] exp_v);
    logic [31:0] old_v;
    int n;
    old_v = fvel;
    n = 0;
    while (fvel === old_v && n < 40) begin
      @(negedge clk_in);
      n++;
    end
    chk("follower velocity", exp_v, fvel);
  endtask : step_vel

  task automatic test_reset_values;
    chk("tracking", 32'h0000_0000, {31'h0, tracking});
    chk("external", 32'h0000_0001, {31'h0, ext_sel});
    chk("ratio", {3'h0, egf_pkg::RATIO_ONE}, {3'h0, ratio_rb});
    chk("master position", 32'h0000_0000, mpos);
  endtask : test_reset_values

  task automatic test_ratio_limits;
    write_ratio(29'h0000_0000);
    chk("ratio", {3'h0, egf_pkg::RATIO_MIN}, {3'h0, ratio_rb});
    write_ratio(29'h1FFF_FFFF);
    chk("ratio", {3'h0, egf_pkg::RATIO_MAX}, {3'h0, ratio_rb});
    write_ratio(29'h0180_0000);
    chk("ratio", 32'h0180_0000, {3'h0, ratio_rb});
    @(negedge clk_in);
    velocity_data_in = 32'h0000_000A;
    velocity_write_in = 1'b1;
    @(negedge clk_in);
    velocity_write_in = 1'b0;
    chk("internal velocity", 32'h0000_000A, vel_rb);
  endtask : test_ratio_limits

  task automatic test_internal_ramp;
    logic [31:0] up[4] = '{32'h3, 32'h6, 32'h9, 32'hA};
    logic [31:0] dn[4] = '{32'h7, 32'h4, 32'h1, 32'h0};
    rate_in = 32'h0000_0003;
    pulse_cmd(7'h20);
    chk("external", 32'h0000_0000, {31'h0, ext_sel});
    pulse_cmd(7'h10);
    chk("tracking", 32'h0000_0001, {31'h0, tracking});
    // ratio 1.5 is set, yet the internal target stays unscaled
    for (int i = 0; i < 4; i++) step_vel(up[i]);
    pulse_cmd(7'h08);
    chk("tracking", 32'h0000_0000, {31'h0, tracking});
    for (int i = 0; i < 4; i++) step_vel(dn[i]);
  endtask : test_internal_ramp

  task automatic test_external_gearing;
    run = 1'b1;
    dir = 1'b1;
    pulse_cmd(7'h60);
    chk("external", 32'h0000_0001, {31'h0, ext_sel});
    // positive ratio 2.0 from the controlling side
    write_ratio(29'h0200_0000);
    repeat (48) @(negedge clk_in);
    chk("master velocity", 32'h0000_0004, mvel);
    pulse_cmd(7'h10);
    step_vel(32'h0000_0003);
    step_vel(32'h0000_0006);
    step_vel(32'h0000_0008);
    // one modest step back to 1.0 while moving
    write_ratio(29'h0100_0000);
    step_vel(32'h0000_0005);
    step_vel(32'h0000_0004);
    pulse_cmd(7'h08);
    step_vel(32'h0000_0001);
    step_vel(32'h0000_0000);
    dir = 1'b0;
    repeat (48) @(negedge clk_in);
    chk("master velocity", 32'hFFFF_FFFC, mvel);
    run = 1'b0;
    repeat (8) @(negedge clk_in);
    position_write_in = 1'b1;
    @(negedge clk_in);
    position_write_in = 1'b0;
    chk("master position", 32'h0000_0000, mpos);
    // 64 clocks of run give exactly 16 master steps, still counting down
    run = 1'b1;
    repeat (64) @(negedge clk_in);
    run = 1'b0;
    repeat (8) @(negedge clk_in);
    chk("master position", 32'hFFFF_FFF0, mpos);
    // download clears the master position as well
    pulse_cmd(7'h02);
    chk("master position", 32'h0000_0000, mpos);
    index_pos = 32'h0000_1234;
    repeat (3) @(negedge clk_in);
    chk("commanded position", 32'h0000_1234, cpos);
  endtask : test_external_gearing

  task automatic test_forced_off;
    pulse_cmd(7'h10);
    pulse_cmd(7'h01);
    chk("tracking", 32'h0000_0000, {31'h0, tracking});
    write_ratio(29'h0180_0000);
    pulse_cmd(7'h20);
    pulse_cmd(7'h10);
    pulse_cmd(7'h04);
    chk("tracking", 32'h0000_0000, {31'h0, tracking});
    chk("ratio", {3'h0, egf_pkg::RATIO_ONE}, {3'h0, ratio_rb});
    chk("external", 32'h0000_0001, {31'h0, ext_sel});
  endtask : test_forced_off

  initial begin
    reset_in = 1'b1;
    cmd_in = egf_pkg::egf_cmd_type'(7'h00);
    ratio_write_in = 1'b0;
    ratio_data_in = 29'h0000_0000;
    velocity_write_in = 1'b0;
    velocity_data_in = 32'h0000_0000;
    rate_in = 32'h0000_0000;
    position_write_in = 1'b0;
    index_pos = 32'h0000_0000;
    run = 1'b0;
    dir = 1'b1;
    repeat (12) @(negedge clk_in);
    reset_in = 1'b0;
    @(negedge clk_in);
    test_reset_values();
    test_ratio_limits();
    test_internal_ramp();
    test_external_gearing();
    test_forced_off();
    complete_run();
  end
endmodule : egf_follower_tb_top

`default_nettype wire
